// [shared/cpcr_pkg.sv]
`default_nettype none

package cpcr_pkg;

  // Frame layout: command, address code, parity, then the data byte.
  localparam int unsigned FRAME_BITS    = 16;
  localparam int unsigned CMD_HI        = 15;
  localparam int unsigned CMD_LO        = 14;
  localparam int unsigned ADDR_HI       = 13;
  localparam int unsigned ADDR_LO       = 9;
  localparam logic [1:0]  CMD_WRITE     = 2'h1;
  localparam logic [4:0]  CAN_CFG_ADDR  = 5'h10;
  localparam logic [4:0]  PIN_CFG_ADDR  = 5'h11;
  localparam logic [4:0]  HDR_LAST_BIT  = 5'h07;
  localparam logic [4:0]  FRAME_LAST    = 5'h0F;
  localparam logic [4:0]  BIT_CNT_ONE   = 5'h01;

  // can_transceiver_config fields.
  localparam int unsigned CAN_MODE_HI   = 7;
  localparam int unsigned CAN_MODE_LO   = 6;
  localparam int unsigned CAN_SLEW_HI   = 5;
  localparam int unsigned CAN_SLEW_LO   = 4;
  localparam int unsigned CAN_WAKE_ONE  = 3;
  localparam int unsigned CAN_FAIL_NOW  = 0;
  localparam logic [7:0]  CAN_CFG_WMASK = 8'hF9;
  localparam logic [7:0]  CAN_CFG_RST   = 8'h80;
  localparam logic [7:0]  PIN_CFG_RST   = 8'h00;

  // Dominant pulse counts.
  localparam int unsigned PCNT_W        = 3;
  localparam logic [2:0]  WAKE_PULSES_3 = 3'h3;
  localparam logic [2:0]  WAKE_PULSES_1 = 3'h1;
  localparam logic [2:0]  FAIL_PULSES   = 3'h5;

  localparam int unsigned NUM_PINS      = 4;
  localparam int unsigned NUM_LOW_SIDE_PINS = 2;

  typedef enum logic [1:0] {
    CPCR_CAN_SLEEP      = 2'b00,
    CPCR_CAN_RX_ONLY    = 2'b01,
    CPCR_CAN_SLEEP_WAKE = 2'b10,
    CPCR_CAN_TXRX       = 2'b11
  } cpcr_can_mode_t;

  typedef enum logic [1:0] {
    CPCR_SLEW_FAST   = 2'b00,
    CPCR_SLEW_MEDIUM = 2'b01,
    CPCR_SLEW_SLOW   = 2'b10,
    CPCR_SLEW_FAST_B = 2'b11
  } cpcr_slew_t;

  typedef enum logic [1:0] {
    CPCR_PIN_OFF   = 2'b00,
    CPCR_PIN_WAKE  = 2'b01,
    CPCR_PIN_DRV_A = 2'b10,
    CPCR_PIN_DRV_B = 2'b11
  } cpcr_pin_cfg_t;

  typedef enum logic [2:0] {
    CPCR_SPI_IDLE = 3'b000,
    CPCR_SPI_HDR  = 3'b001,
    CPCR_SPI_DATA = 3'b010,
    CPCR_SPI_DONE = 3'b011,
    CPCR_SPI_ERR  = 3'b100
  } cpcr_spi_st_t;

endpackage : cpcr_pkg

`default_nettype wire

// [hdl/cpcr_sync_filt.sv]
`default_nettype none

// Three-stage synchroniser; the filtered level only moves when stages two and three agree.
module cpcr_sync_filt #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_level[g] <= 1'b0;
          o_rise[g]  <= 1'b0;
        end else begin
          if (s2_q[g] == s3_q[g]) begin
            o_level[g] <= s3_q[g];
          end
          o_rise[g] <= s2_q[g] & s3_q[g] & ~o_level[g];
        end
      end
    end
  endgenerate

endmodule : cpcr_sync_filt

`default_nettype wire

// [hdl/cpcr_pulse_cnt.sv]
`default_nettype none

// Counts pulses while armed and fires once the target is reached, then starts over.
module cpcr_pulse_cnt
  import cpcr_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_arm,
  input  wire logic              i_pulse,
  input  wire logic [PCNT_W-1:0] i_target,
  output logic                   o_hit
);

  logic [PCNT_W-1:0] cnt_q;
  logic [PCNT_W-1:0] cnt_inc;

  assign cnt_inc = cnt_q + {{(PCNT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge i_clk) begin
    if (i_srst || !i_arm) begin
      cnt_q <= '0;
      o_hit <= 1'b0;
    end else if (i_pulse && cnt_inc >= i_target) begin
      cnt_q <= '0;
      o_hit <= 1'b1;
    end else begin
      cnt_q <= i_pulse ? cnt_inc : cnt_q;
      o_hit <= 1'b0;
    end
  end

endmodule : cpcr_pulse_cnt

`default_nettype wire

// [hdl/cpcr_top.sv]
`default_nettype none

module cpcr_top
  import cpcr_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire logic                 i_spi_sck,
  input  wire logic                 i_spi_cs_n,
  input  wire logic                 i_spi_mosi,
  output logic                      o_spi_miso,
  input  wire logic                 i_normal_mode,
  input  wire logic                 i_low_power_mode,
  input  wire logic                 i_bus_dominant,
  input  wire logic                 i_xcvr_tx_input,
  input  wire logic                 i_bus_fail_detect,
  output logic [7:0]                o_can_cfg,
  output logic [7:0]                o_pin_cfg,
  output logic                      o_xcvr_sleep,
  output logic                      o_xcvr_rx_en,
  output logic                      o_xcvr_tx_en,
  output logic                      o_bus_wake_en,
  output logic [1:0]                o_slew_rate,
  output logic                      o_wake_single,
  output logic                      o_dev_wake,
  output logic                      o_wake_irq,
  output logic                      o_fail_irq,
  output logic [cpcr_pkg::NUM_PINS-1:0] o_pin_wake_en,
  output logic [cpcr_pkg::NUM_PINS-1:0] o_pin_high_side_drive,
  output logic [cpcr_pkg::NUM_PINS-1:0] o_pin_low_side_drive
);

  import cpcr_pkg::*;

  // Select is synchronised active high so that cleared stages read as deselected.
  logic [2:0]   spi_lvl;
  logic [2:0]   spi_rise;
  logic [2:0]   dev_lvl;
  logic [2:0]   dev_rise;
  logic         sck_lvl;
  logic         cs_n_lvl;
  logic         mosi_lvl;
  logic         sck_rise;
  logic         sck_prev_q;
  logic         sck_fall;

  cpcr_sync_filt #(
    .W (3)
  ) u_spi_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_spi_mosi, ~i_spi_cs_n, i_spi_sck}),
    .o_level (spi_lvl),
    .o_rise  (spi_rise)
  );

  cpcr_sync_filt #(
    .W (3)
  ) u_dev_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_bus_fail_detect, i_xcvr_tx_input, i_bus_dominant}),
    .o_level (dev_lvl),
    .o_rise  (dev_rise)
  );

  assign sck_lvl  = spi_lvl[0];
  assign cs_n_lvl = ~spi_lvl[1];
  assign mosi_lvl = spi_lvl[2];
  assign sck_rise = spi_rise[0];
  assign sck_fall = sck_prev_q & ~sck_lvl;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_lvl;
    end
  end

  cpcr_spi_st_t st_q;
  logic [4:0]   bit_cnt_q;
  logic [15:0]  shift_q;
  logic [15:0]  shift_d;
  logic [7:0]   miso_sr_q;
  logic [7:0]   rd_byte;
  logic [4:0]   hdr_addr;
  logic         commit;
  logic [7:0]   can_q;
  logic [7:0]   pin_q;

  assign shift_d  = {shift_q[14:0], mosi_lvl};
  assign hdr_addr = shift_d[ADDR_LO-8 +: 5];
  // A frame only counts when exactly sixteen bits arrived before select is released.
  assign commit   = (st_q == CPCR_SPI_DONE) && cs_n_lvl;

  always_comb begin
    if (hdr_addr == CAN_CFG_ADDR) begin
      rd_byte = can_q;
    end else if (hdr_addr == PIN_CFG_ADDR) begin
      rd_byte = pin_q;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q      <= CPCR_SPI_IDLE;
      bit_cnt_q <= 5'h00;
      shift_q   <= 16'h0000;
    end else if (cs_n_lvl) begin
      st_q      <= CPCR_SPI_IDLE;
      bit_cnt_q <= 5'h00;
    end else begin
      case (st_q)
        CPCR_SPI_IDLE: begin
          st_q      <= CPCR_SPI_HDR;
          bit_cnt_q <= 5'h00;
        end
        CPCR_SPI_HDR: begin
          if (sck_rise) begin
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
            if (bit_cnt_q == HDR_LAST_BIT) begin
              st_q <= CPCR_SPI_DATA;
            end
          end
        end
        CPCR_SPI_DATA: begin
          if (sck_rise) begin
            shift_q   <= shift_d;
            bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
            if (bit_cnt_q == FRAME_LAST) begin
              st_q <= CPCR_SPI_DONE;
            end
          end
        end
        CPCR_SPI_DONE: begin
          if (sck_rise) begin
            st_q <= CPCR_SPI_ERR;
          end
        end
        CPCR_SPI_ERR: begin
          st_q <= CPCR_SPI_ERR;
        end
        default: begin
          st_q <= CPCR_SPI_IDLE;
        end
      endcase
    end
  end

  // Read data is the addressed register, shifted out MSB first on falling clock edges.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      miso_sr_q  <= 8'h00;
      o_spi_miso <= 1'b0;
    end else if (cs_n_lvl) begin
      miso_sr_q  <= 8'h00;
      o_spi_miso <= 1'b0;
    end else if (st_q == CPCR_SPI_HDR && sck_rise && bit_cnt_q == HDR_LAST_BIT) begin
      miso_sr_q <= rd_byte;
    end else if (st_q == CPCR_SPI_DATA && sck_fall) begin
      o_spi_miso <= miso_sr_q[7];
      miso_sr_q  <= {miso_sr_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      can_q <= CAN_CFG_RST;
      pin_q <= PIN_CFG_RST;
    end else if (commit && shift_q[CMD_HI:CMD_LO] == CMD_WRITE) begin
      if (shift_q[ADDR_HI:ADDR_LO] == CAN_CFG_ADDR) begin
        can_q <= shift_q[7:0] & CAN_CFG_WMASK;
      end else if (shift_q[ADDR_HI:ADDR_LO] == PIN_CFG_ADDR) begin
        pin_q <= shift_q[7:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_can_cfg <= CAN_CFG_RST;
      o_pin_cfg <= PIN_CFG_RST;
    end else begin
      o_can_cfg <= can_q;
      o_pin_cfg <= pin_q;
    end
  end

  logic           normal_prev_q;
  logic           seen_normal_q;
  logic           force_wake_q;
  cpcr_can_mode_t eff_mode;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      normal_prev_q <= 1'b0;
      seen_normal_q <= 1'b0;
      force_wake_q  <= 1'b0;
    end else begin
      normal_prev_q <= i_normal_mode;
      if (!i_normal_mode) begin
        force_wake_q <= 1'b0;
      end else if (!normal_prev_q && !seen_normal_q) begin
        force_wake_q  <= 1'b1;
        seen_normal_q <= 1'b1;
      end
    end
  end

  // Forcing is held for the whole first normal stay, so a mode written during it lands but waits.
  assign eff_mode = force_wake_q ? CPCR_CAN_SLEEP_WAKE
                                 : cpcr_can_mode_t'(can_q[CAN_MODE_HI:CAN_MODE_LO]);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_xcvr_sleep  <= 1'b1;
      o_xcvr_rx_en  <= 1'b0;
      o_xcvr_tx_en  <= 1'b0;
      o_bus_wake_en <= 1'b1;
    end else begin
      case (eff_mode)
        CPCR_CAN_SLEEP: begin
          o_xcvr_sleep  <= 1'b1;
          o_xcvr_rx_en  <= 1'b0;
          o_xcvr_tx_en  <= 1'b0;
          o_bus_wake_en <= 1'b0;
        end
        CPCR_CAN_RX_ONLY: begin
          o_xcvr_sleep  <= 1'b0;
          o_xcvr_rx_en  <= 1'b1;
          o_xcvr_tx_en  <= 1'b0;
          o_bus_wake_en <= 1'b0;
        end
        CPCR_CAN_SLEEP_WAKE: begin
          o_xcvr_sleep  <= 1'b1;
          o_xcvr_rx_en  <= 1'b0;
          o_xcvr_tx_en  <= 1'b0;
          o_bus_wake_en <= 1'b1;
        end
        default: begin
          o_xcvr_sleep  <= 1'b0;
          o_xcvr_rx_en  <= 1'b1;
          o_xcvr_tx_en  <= 1'b1;
          o_bus_wake_en <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_slew_rate   <= CPCR_SLEW_FAST;
      o_wake_single <= 1'b0;
    end else begin
      case (cpcr_slew_t'(can_q[CAN_SLEW_HI:CAN_SLEW_LO]))
        CPCR_SLEW_MEDIUM: o_slew_rate <= CPCR_SLEW_MEDIUM;
        CPCR_SLEW_SLOW:   o_slew_rate <= CPCR_SLEW_SLOW;
        default:          o_slew_rate <= CPCR_SLEW_FAST;
      endcase
      o_wake_single <= can_q[CAN_WAKE_ONE];
    end
  end

  logic       wake_hit;
  logic [2:0] wake_target;

  assign wake_target = can_q[CAN_WAKE_ONE] ? WAKE_PULSES_1 : WAKE_PULSES_3;

  cpcr_pulse_cnt u_wake_cnt (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_arm    (eff_mode == CPCR_CAN_SLEEP_WAKE),
    .i_pulse  (dev_rise[0]),
    .i_target (wake_target),
    .o_hit    (wake_hit)
  );

  // In low-power mode the wake goes to the device, otherwise it becomes an interrupt only in normal mode.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dev_wake <= 1'b0;
      o_wake_irq <= 1'b0;
    end else begin
      o_dev_wake <= wake_hit & i_low_power_mode;
      o_wake_irq <= wake_hit & ~i_low_power_mode & i_normal_mode;
    end
  end

  logic fail_hit;
  logic fail_early;
  logic fail_done_q;

  assign fail_early = can_q[CAN_FAIL_NOW];

  cpcr_pulse_cnt u_fail_cnt (
    .i_clk    (i_clk),
    .i_srst   (i_srst),
    .i_arm    (dev_lvl[2] & ~fail_early & ~fail_done_q),
    .i_pulse  (dev_rise[1]),
    .i_target (FAIL_PULSES),
    .o_hit    (fail_hit)
  );

  // One report per failure; a new report needs the failure to clear first.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_fail_irq  <= 1'b0;
      fail_done_q <= 1'b0;
    end else begin
      o_fail_irq <= (fail_early & dev_rise[2])
                  | (fail_hit & ~fail_done_q);
      if (!dev_lvl[2]) begin
        fail_done_q <= 1'b0;
      end else if (fail_hit || (fail_early && dev_rise[2])) begin
        fail_done_q <= 1'b1;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      cpcr_pin_cfg_t fld;
      assign fld = cpcr_pin_cfg_t'(pin_q[2*p +: 2]);
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_pin_wake_en[p]         <= 1'b0;
          o_pin_high_side_drive[p] <= 1'b0;
          o_pin_low_side_drive[p]  <= 1'b0;
        end else begin
          o_pin_wake_en[p] <= (fld == CPCR_PIN_WAKE);
          if (p >= NUM_LOW_SIDE_PINS) begin
            o_pin_high_side_drive[p] <= (fld == CPCR_PIN_DRV_A)
                                      || (fld == CPCR_PIN_DRV_B);
            o_pin_low_side_drive[p]  <= 1'b0;
          end else begin
            o_pin_high_side_drive[p] <= (fld == CPCR_PIN_DRV_B);
            o_pin_low_side_drive[p]  <= (fld == CPCR_PIN_DRV_A);
          end
        end
      end
    end
  endgenerate

endmodule : cpcr_top

`default_nettype wire

// [tb/cpcr_monitor.sv]
`default_nettype none

module cpcr_monitor (
  input wire logic                          i_clk,
  input wire logic                          i_srst,
  input wire logic                          i_normal_mode,
  input wire logic [7:0]                    o_can_cfg,
  input wire logic [7:0]                    o_pin_cfg,
  input wire logic                          o_xcvr_sleep,
  input wire logic                          o_xcvr_rx_en,
  input wire logic                          o_xcvr_tx_en,
  input wire logic                          o_bus_wake_en,
  input wire logic [1:0]                    o_slew_rate,
  input wire logic                          o_dev_wake,
  input wire logic                          o_wake_irq,
  input wire logic                          o_fail_irq,
  input wire logic [cpcr_pkg::NUM_PINS-1:0] o_pin_wake_en,
  input wire logic [cpcr_pkg::NUM_PINS-1:0] o_pin_high_side_drive,
  input wire logic [cpcr_pkg::NUM_PINS-1:0] o_pin_low_side_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpcr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_rst;
    $past(i_srst) |-> o_can_cfg == 8'h80 && o_pin_cfg == 8'h00 && o_xcvr_sleep && o_bus_wake_en;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_mask;
    o_can_cfg[2:1] == 2'b00;
  endproperty
  a_mask: assert property (p_mask) else $error("unused bits not zero");
  property p_slew;
    o_slew_rate != 2'b11;
  endproperty
  a_slew: assert property (p_slew) else $error("slew code 11 seen");
  property p_pin_ex;
    (o_pin_wake_en & (o_pin_high_side_drive | o_pin_low_side_drive)) == 4'h0;
  endproperty
  a_pin_ex: assert property (p_pin_ex) else $error("wake input with driver");
  property p_upper_low;
    o_pin_low_side_drive[3:2] == 2'b00;
  endproperty
  a_upper_low: assert property (p_upper_low) else $error("low side on upper pins");
  // Decode is compared only once the copy has settled, since latencies may differ.
  property p_pin0;
    $stable(o_pin_cfg) [*3] |-> o_pin_low_side_drive[0] == (o_pin_cfg[1:0] == 2'b10)
      && o_pin_high_side_drive[0] == (o_pin_cfg[1:0] == 2'b11);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin 0 decode wrong");
  property p_tx;
    o_xcvr_tx_en |-> o_xcvr_rx_en && !o_xcvr_sleep;
  endproperty
  a_tx: assert property (p_tx) else $error("transmit without receive");
  property p_sleep;
    o_xcvr_sleep |-> !o_xcvr_rx_en && !o_xcvr_tx_en;
  endproperty
  a_sleep: assert property (p_sleep) else $error("asleep but active");
  property p_wirq;
    o_wake_irq |-> $past(i_normal_mode) && !o_dev_wake ##1 !o_wake_irq;
  endproperty
  a_wirq: assert property (p_wirq) else $error("wake irq outside normal");
  property p_dwake;
    o_dev_wake |-> o_bus_wake_en ##1 !o_dev_wake;
  endproperty
  a_dwake: assert property (p_dwake) else $error("wake without enable");
  property p_fpulse;
    o_fail_irq |=> !o_fail_irq;
  endproperty
  a_fpulse: assert property (p_fpulse) else $error("failure pulse too long");
  c_dw: cover property (o_dev_wake);
  c_wi: cover property (o_wake_irq);
  c_fi: cover property (o_fail_irq);
endmodule : cpcr_monitor

bind cpcr_top cpcr_monitor u_mon (
  .i_clk(i_clk), .i_srst(i_srst), .i_normal_mode(i_normal_mode),
  .o_can_cfg(o_can_cfg), .o_pin_cfg(o_pin_cfg), .o_xcvr_sleep(o_xcvr_sleep),
  .o_xcvr_rx_en(o_xcvr_rx_en), .o_xcvr_tx_en(o_xcvr_tx_en), .o_bus_wake_en(o_bus_wake_en),
  .o_slew_rate(o_slew_rate), .o_dev_wake(o_dev_wake), .o_wake_irq(o_wake_irq),
  .o_fail_irq(o_fail_irq), .o_pin_wake_en(o_pin_wake_en),
  .o_pin_high_side_drive(o_pin_high_side_drive), .o_pin_low_side_drive(o_pin_low_side_drive)
);

`default_nettype wire

// [tb/cpcr_host_model.sv]
`default_nettype none

// Host controller acting as SPI master, mode 0, MSB first.
module cpcr_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_miso,
  output logic            o_sck,
  output logic            o_cs_n,
  output logic            o_mosi,
  output logic [7:0]      o_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_rd = 8'h00;
  end
  // Ten cycles per half period keeps well clear of the synchroniser's minimum.
  task automatic half;
    repeat (10) @(posedge i_clk);
  endtask : half
  // A bit count other than 16 is only used to provoke a refused frame.
  task automatic xfer(input logic [15:0] w, input int n);
    o_cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      o_mosi <= w[15 - (i % 16)];
      half();
      o_sck <= 1'b1;
      if (i >= 8) begin
        o_rd <= {o_rd[6:0], i_miso};
      end
      half();
      o_sck <= 1'b0;
    end
    half();
    o_cs_n <= 1'b1;
    // A released data line must not keep showing the last bit.
    o_mosi <= ~o_mosi;
    half();
  endtask : xfer
endmodule : cpcr_host_model

`default_nettype wire

// [tb/tb_cpcr_top.sv]
`default_nettype none

module tb_cpcr_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cpcr_pkg::*;
  logic       i_clk = 1'b0;
  logic       srst = 1'b1;
  logic       nrm = 1'b0;
  logic       low_pwr = 1'b0;
  logic       dom = 1'b0;
  logic       txin = 1'b0;
  logic       fd = 1'b0;
  logic       sck, cs_n, mosi, miso, sl, rx, tx, we, ws, dw, wi, fi;
  logic [7:0] can, pin, rd;
  logic [1:0] slew;
  logic [3:0] pwe, phs, pls;
  logic [7:0] n_dw = 8'h00;
  logic [7:0] n_wi = 8'h00;
  logic [7:0] n_fi = 8'h00;
  int         fail_count = 0;
  int         cmp_count = 0;

  always #10 i_clk = ~i_clk;

  cpcr_top DUT (
    .i_clk(i_clk), .i_srst(srst), .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .i_normal_mode(nrm), .i_low_power_mode(low_pwr), .i_bus_dominant(dom),
    .i_xcvr_tx_input(txin), .i_bus_fail_detect(fd), .o_can_cfg(can), .o_pin_cfg(pin),
    .o_xcvr_sleep(sl), .o_xcvr_rx_en(rx), .o_xcvr_tx_en(tx), .o_bus_wake_en(we),
    .o_slew_rate(slew), .o_wake_single(ws), .o_dev_wake(dw), .o_wake_irq(wi),
    .o_fail_irq(fi), .o_pin_wake_en(pwe), .o_pin_high_side_drive(phs),
    .o_pin_low_side_drive(pls)
  );
  cpcr_host_model host (
    .i_clk(i_clk), .i_miso(miso), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .o_rd(rd)
  );

  always @(posedge i_clk) begin
    if (dw === 1'b1) n_dw <= n_dw + 8'h01;
    if (wi === 1'b1) n_wi <= n_wi + 8'h01;
    if (fi === 1'b1) n_fi <= n_fi + 8'h01;
  end

  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [1:0] c, input logic [4:0] a, input logic [7:0] d, input int n);
    host.xfer({c, a, 1'b0, d}, n);
    repeat (4) @(posedge i_clk);
  endtask : wr
  task automatic wc(input logic [7:0] d);
    wr(CMD_WRITE, CAN_CFG_ADDR, d, 16);
  endtask : wc
  task automatic pulse(input bit on_tx, input int n);
    repeat (n) begin
      if (on_tx) txin <= 1'b1; else dom <= 1'b1;
      repeat (8) @(posedge i_clk);
      if (on_tx) txin <= 1'b0; else dom <= 1'b0;
      repeat (8) @(posedge i_clk);
    end
    repeat (8) @(posedge i_clk);
  endtask : pulse

  task automatic t_modes;
    logic [3:0] e [4] = '{4'b1000, 4'b0100, 4'b1001, 4'b0110};
    for (int m = 0; m < 4; m++) begin
      wc({2'(m), 6'h00});
      chk({4'h0, sl, rx, tx, we}, {4'h0, e[m]});
    end
    wc(8'hFF);
    chk(can, 8'hF9);
    for (int s = 0; s < 4; s++) begin
      wc({2'b11, 2'(s), 4'h8});
      chk({6'h00, slew}, (s == 3) ? 8'h00 : 8'(s));
      chk({7'h00, ws}, 8'h01);
    end
  endtask : t_modes
  task automatic t_normal;
    nrm <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk({4'h0, sl, rx, tx, we}, 8'h09);
    nrm <= 1'b0;
    repeat (4) @(posedge i_clk);
    nrm <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk({4'h0, sl, rx, tx, we}, 8'h06);
    nrm <= 1'b0;
  endtask : t_normal
  task automatic t_wake;
    low_pwr <= 1'b1;
    wc(8'h80);
    pulse(0, 2);
    chk(n_dw, 8'h00);
    pulse(0, 1);
    chk(n_dw, 8'h01);
    wc(8'h88);
    pulse(0, 1);
    chk(n_dw, 8'h02);
    low_pwr <= 1'b0;
    nrm <= 1'b1;
    repeat (4) @(posedge i_clk);
    pulse(0, 1);
    chk(n_wi, 8'h01);
    wc(8'h08);
    pulse(0, 1);
    chk(n_wi, 8'h01);
    nrm <= 1'b0;
  endtask : t_wake
  task automatic t_fail;
    wc(8'h01);
    fd <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk(n_fi, 8'h01);
    fd <= 1'b0;
    wc(8'h00);
    fd <= 1'b1;
    pulse(1, 4);
    chk(n_fi, 8'h01);
    pulse(1, 1);
    chk(n_fi, 8'h02);
    fd <= 1'b0;
  endtask : t_fail
  task automatic t_pins;
    logic [3:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 4'(i);
      wr(CMD_WRITE, PIN_CFG_ADDR, {4{v[1:0]}}, 16);
      chk({4'h0, pwe}, (i == 1) ? 8'h0F : 8'h00);
      chk({4'h0, phs}, (i == 3) ? 8'h0F : (i == 2) ? 8'h0C : 8'h00);
      chk({4'h0, pls}, (i == 2) ? 8'h03 : 8'h00);
    end
    wr(CMD_WRITE, PIN_CFG_ADDR, 8'h1B, 16);
    chk(rd, 8'hFF);
    chk({pwe, phs}, 8'h41);
    chk({4'h0, pls}, 8'h02);
    wr(CMD_WRITE, PIN_CFG_ADDR, 8'h00, 15);
    wr(2'b10, PIN_CFG_ADDR, 8'h00, 16);
    wr(CMD_WRITE, 5'h12, 8'h00, 16);
    wr(CMD_WRITE, PIN_CFG_ADDR, 8'h00, 17);
    chk(pin, 8'h1B);
  endtask : t_pins

  initial begin
    repeat (60000) @(posedge i_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    srst <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk(can, 8'h80);
    chk({pin[7:4], sl, rx, tx, we}, 8'h09);
    t_modes();
    t_normal();
    t_wake();
    t_fail();
    t_pins();
    print_verdict();
  end
endmodule : tb_cpcr_top

`default_nettype wire
